// File: core/vocr_pkg.sv
`default_nettype none
package vocr_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] RIGHT_GAIN_IDX = 8'h05;
  localparam logic [ADDR_W-1:0] OUT_CFG_IDX = 8'h06;
  localparam logic [ADDR_W-1:0] RSVD_IDX = 8'h07;
  localparam logic [ADDR_W-1:0] RATE_RANGE_IDX = 8'h03;
  localparam logic [ADDR_W-1:0] RIGHT_GAIN_ADDR = 8'h14;
  localparam logic [ADDR_W-1:0] OUT_CFG_ADDR = 8'h18;
  localparam logic [ADDR_W-1:0] RSVD_ADDR = 8'h1C;
  localparam logic [ADDR_W-1:0] RATE_RANGE_ADDR = 8'h0C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_TOPO_BIT = 7;
  localparam int CFG_RATE_HI = 6;
  localparam int CFG_RATE_LO = 4;
  localparam int CFG_AGAIN_HI = 3;
  localparam int CFG_AGAIN_LO = 2;
  localparam int CFG_SRC_BIT = 1;
  localparam int CFG_KEEP_BIT = 0;
  localparam int RANGE_BIT = 0;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] GAIN_RESET = 8'hCF;
  localparam logic [7:0] GAIN_MAX_CODE = 8'hFF;
  localparam logic [7:0] GAIN_MIN_CODE = 8'h07;
  localparam logic [7:0] OUT_CFG_RESET = 8'h51;
  localparam logic [7:0] RSVD_RESET = 8'h00;
  localparam logic [1:0] AGAIN_RSVD = 2'h3;
  // max gain in half-dB steps: +24 dB
  localparam int GAIN_MAX_HALF_DB = 48;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;

  typedef enum logic [1:0] {
    VOCR_RESP_OKAY = 2'h0,
    VOCR_RESP_SLVERR = 2'h2,
    VOCR_RESP_DECERR = 2'h3
  } vocr_resp_e;

  typedef enum logic {
    VOCR_STEREO_BRIDGE,
    VOCR_PARALLEL_BRIDGE
  } vocr_topo_e;

  // decoded output settings handed to the amplifier datapath
  typedef struct packed {
    logic parallelOutputSelect;
    logic parallelSourceChannel;
    logic [4:0] switchMultiple;
    logic halveSwitchRate;
    logic [1:0] analogGainCode;
    logic sampleRateRangeSelect;
  } vocr_outcfg_s;

  typedef struct packed {
    logic muted;
    logic signed [8:0] gainHalfDb;
    logic [7:0] code;
  } vocr_gain_s;

endpackage
`default_nettype wire

// File: core/vocr_regs.sv
// How it works
// - right gain is 8-bit read/write; code FF means +24 dB
// - right gain resets to CF, which is 0 dB
// - right gain code 07 gives the lowest unmuted gain, -100 dB
// - right gain codes below 07 mute the right channel
// - config bit 7 picks stereo bridge (0) or parallel bridge (1); resets 0
// - config bits 6:4 pick 6,8,10,12,14,16,20,24 times frame clock
// - switching rate code resets to 101, sixteen times frame clock
// - double-rate mode halves the switching frequency
// - config bits 3:2 pick analog gain 19.2, 22.6, 25 dBV; reset 00
// - config bit 1 picks right (0) or left (1) source in parallel mode
// - double-rate bit makes the port take 88.2/96 kHz instead of 32-48 kHz
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none

module vocr_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // decoded settings
  output vocr_pkg::vocr_outcfg_s outCfg,
  output vocr_pkg::vocr_gain_s rightGain,
  // status
  output logic badGainWrite,
  output logic reservedAccess
);

  // ----------------------------------------------------------------
  // access state
  // ----------------------------------------------------------------
  typedef enum {
    VOCR_IDLE,
    VOCR_ACK
  } vocr_state_e;

  vocr_state_e state;
  vocr_state_e next_state;
  logic [7:0] gainCode;
  logic [7:0] next_gainCode;
  logic [7:0] cfgReg;
  logic [7:0] next_cfgReg;
  logic rangeSel;
  logic next_rangeSel;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic [1:0] next_response;
  logic next_badGainWrite;
  logic next_reservedAccess;
  vocr_pkg::vocr_outcfg_s next_outCfg;
  vocr_pkg::vocr_gain_s next_rightGain;
  logic req;
  logic lowLane;
  logic xferEdge;
  logic wrCommit;

  assign req = read | write;
  assign lowLane = byteenable[0];
  // a transfer completes at the edge where waitrequest is sampled low
  assign xferEdge = req & ~waitrequest;
  assign wrCommit = xferEdge & write & lowLane;

  // ----------------------------------------------------------------
  // bus slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_readdata = readdata;
    next_waitrequest = 1'b1;
    next_response = response;
    unique case (state)
      VOCR_IDLE:
      begin
        if (req)
        begin
          next_state = VOCR_ACK;
          next_waitrequest = 1'b0;
          next_response = vocr_pkg::VOCR_RESP_OKAY;
          next_readdata = vocr_pkg::UNMAPPED_DATA;
          unique case (address)
            vocr_pkg::RIGHT_GAIN_ADDR:
            begin
              next_readdata = {24'h000000, gainCode};
            end
            vocr_pkg::OUT_CFG_ADDR:
            begin
              next_readdata = {24'h000000, cfgReg};
            end
            vocr_pkg::RATE_RANGE_ADDR:
            begin
              next_readdata = {31'h0, rangeSel};
            end
            vocr_pkg::RSVD_ADDR:
            begin
              // reserved register: no storage, access reported
              next_readdata = {24'h000000, vocr_pkg::RSVD_RESET};
              next_response = vocr_pkg::VOCR_RESP_SLVERR;
            end
            default:
            begin
              next_response = vocr_pkg::VOCR_RESP_DECERR;
            end
          endcase
        end
      end
      VOCR_ACK:
      begin
        // writes commit at this edge; the answer already stands on the bus
        next_state = VOCR_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // stored fields: a write lands only when the transfer completes
  // ----------------------------------------------------------------
  always_comb
  begin
    next_gainCode = gainCode;
    next_cfgReg = cfgReg;
    next_rangeSel = rangeSel;
    // byte lane 0 carries every field; the other lanes are ignored
    if (wrCommit)
    begin
      unique case (address)
        vocr_pkg::RIGHT_GAIN_ADDR:
        begin
          next_gainCode = writedata[7:0];
        end
        vocr_pkg::OUT_CFG_ADDR:
        begin
          // a reserved analog gain code is still stored; it is flagged below
          next_cfgReg = writedata[7:0];
        end
        vocr_pkg::RATE_RANGE_ADDR:
        begin
          next_rangeSel = writedata[vocr_pkg::RANGE_BIT];
        end
        default:
        begin
          // reserved and unmapped slots hold no state
          next_gainCode = gainCode;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // misuse flags, sticky until reset
  // ----------------------------------------------------------------
  always_comb
  begin
    next_badGainWrite = badGainWrite;
    next_reservedAccess = reservedAccess;
    if (wrCommit && (address == vocr_pkg::OUT_CFG_ADDR))
    begin
      next_badGainWrite = badGainWrite |
        (writedata[vocr_pkg::CFG_AGAIN_HI:vocr_pkg::CFG_AGAIN_LO]
         == vocr_pkg::AGAIN_RSVD) |
        ~writedata[vocr_pkg::CFG_KEEP_BIT];
    end
    // any completed access to the reserved slot counts, read or write
    if (xferEdge && (address == vocr_pkg::RSVD_ADDR))
    begin
      next_reservedAccess = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // switching-rate decode
  // ----------------------------------------------------------------
  // multiple of the frame clock for each rate code
  function automatic logic [4:0] switch_multiple(input logic [2:0] rateCode);
    logic [4:0] mult;
    unique case (rateCode)
      3'h0: mult = 5'h06;
      3'h1: mult = 5'h08;
      3'h2: mult = 5'h0A;
      3'h3: mult = 5'h0C;
      3'h4: mult = 5'h0E;
      3'h5: mult = 5'h10;
      3'h6: mult = 5'h14;
      3'h7: mult = 5'h18;
    endcase
    return mult;
  endfunction

  // ----------------------------------------------------------------
  // decode of settings
  // ----------------------------------------------------------------
  always_comb
  begin
    next_outCfg.parallelOutputSelect = cfgReg[vocr_pkg::CFG_TOPO_BIT];
    next_outCfg.parallelSourceChannel = cfgReg[vocr_pkg::CFG_SRC_BIT];
    next_outCfg.analogGainCode =
      cfgReg[vocr_pkg::CFG_AGAIN_HI:vocr_pkg::CFG_AGAIN_LO];
    next_outCfg.sampleRateRangeSelect = rangeSel;
    next_outCfg.halveSwitchRate = rangeSel;
    next_outCfg.switchMultiple =
      switch_multiple(cfgReg[vocr_pkg::CFG_RATE_HI:vocr_pkg::CFG_RATE_LO]);
    next_rightGain.code = gainCode;
    next_rightGain.muted = gainCode < vocr_pkg::GAIN_MIN_CODE;
    // half-dB per code step from FF downward; 07 lands on -200 half-dB
    next_rightGain.gainHalfDb = 9'(vocr_pkg::GAIN_MAX_HALF_DB)
      - 9'(vocr_pkg::GAIN_MAX_CODE - gainCode);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // bus answer
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state <= VOCR_IDLE;
      readdata <= 32'h00000000;
      waitrequest <= 1'b1;
      response <= vocr_pkg::VOCR_RESP_OKAY;
    end
    else
    begin
      state <= next_state;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
      response <= next_response;
    end
  end

  // ----------------------------------------------------------------
  // stored field registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      gainCode <= vocr_pkg::GAIN_RESET;
      cfgReg <= vocr_pkg::OUT_CFG_RESET;
      rangeSel <= 1'b0;
    end
    else
    begin
      gainCode <= next_gainCode;
      cfgReg <= next_cfgReg;
      rangeSel <= next_rangeSel;
    end
  end

  // ----------------------------------------------------------------
  // misuse flag registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      badGainWrite <= 1'b0;
      reservedAccess <= 1'b0;
    end
    else
    begin
      badGainWrite <= next_badGainWrite;
      reservedAccess <= next_reservedAccess;
    end
  end

  // ----------------------------------------------------------------
  // decoded output registers
  // ----------------------------------------------------------------
  // reset shows the decoded reset settings, so no low code reads as unmuted
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      outCfg.parallelOutputSelect <= vocr_pkg::OUT_CFG_RESET[vocr_pkg::CFG_TOPO_BIT];
      outCfg.parallelSourceChannel <= vocr_pkg::OUT_CFG_RESET[vocr_pkg::CFG_SRC_BIT];
      outCfg.switchMultiple <=
        switch_multiple(vocr_pkg::OUT_CFG_RESET[vocr_pkg::CFG_RATE_HI:vocr_pkg::CFG_RATE_LO]);
      outCfg.halveSwitchRate <= 1'b0;
      outCfg.analogGainCode <=
        vocr_pkg::OUT_CFG_RESET[vocr_pkg::CFG_AGAIN_HI:vocr_pkg::CFG_AGAIN_LO];
      outCfg.sampleRateRangeSelect <= 1'b0;
      rightGain.code <= vocr_pkg::GAIN_RESET;
      rightGain.muted <= 1'b0;
      rightGain.gainHalfDb <= 9'h000;
    end
    else
    begin
      outCfg <= next_outCfg;
      rightGain <= next_rightGain;
    end
  end

endmodule
`default_nettype wire

// File: bench/vocr_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module vocr_regs_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  // settings and flags
  input wire vocr_pkg::vocr_outcfg_s outCfg,
  input wire vocr_pkg::vocr_gain_s rightGain,
  input wire logic badGainWrite,
  input wire logic reservedAccess
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic wr;
  logic cw;
  assign wr = write && !waitrequest && byteenable[0];
  assign cw = wr && address == vocr_pkg::OUT_CFG_ADDR;
  function automatic logic [4:0] mult(input logic [2:0] c);
    return (c < 3'h6) ? 5'h06 + {1'b0, c, 1'b0} : ((c == 3'h6) ? 5'h14 : 5'h18);
  endfunction
  gain_apply_a: assert property (wr && address == vocr_pkg::RIGHT_GAIN_ADDR |->
    ##2 rightGain.code == $past(writedata[7:0], 2)) else $error("gain code not applied");
  gain_step_a: assert property (!$past(srst) && !rightGain.muted |->
    rightGain.gainHalfDb == $signed({1'b0, rightGain.code}) - 9'sd207) else $error("gain step");
  mute_code_a: assert property (!$past(srst) |->
    rightGain.muted == (rightGain.code < vocr_pkg::GAIN_MIN_CODE)) else $error("mute wrong");
  topo_apply_a: assert property (cw |-> ##2 outCfg.parallelOutputSelect ==
    $past(writedata[7], 2) && outCfg.parallelSourceChannel == $past(writedata[1], 2))
    else $error("topology not applied");
  rate_apply_a: assert property (cw |->
    ##2 outCfg.switchMultiple == mult($past(writedata[6:4], 2))) else $error("rate wrong");
  again_apply_a: assert property (cw |->
    ##2 outCfg.analogGainCode == $past(writedata[3:2], 2)) else $error("analog gain wrong");
  halve_rate_a: assert property (wr && address == vocr_pkg::RATE_RANGE_ADDR |->
    ##2 outCfg.halveSwitchRate == $past(writedata[0], 2)) else $error("halving wrong");
  bad_flag_a: assert property (cw && (writedata[3:2] == 2'h3 || !writedata[0]) |=>
    badGainWrite) else $error("bad write not flagged");
  rsvd_resp_a: assert property (!waitrequest && address == vocr_pkg::RSVD_ADDR |->
    response == 2'h2 ##1 reservedAccess) else $error("reserved access wrong");
  cover property (cw);
  cover property (rightGain.muted);
  cover property (reservedAccess);
endmodule
bind vocr_regs vocr_regs_chk chk_u (.sys_clk, .srst, .address, .read, .write, .byteenable,
  .writedata, .readdata, .waitrequest, .response, .outCfg, .rightGain, .badGainWrite,
  .reservedAccess);
`default_nettype wire

// File: bench/vocr_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module vocr_regs_tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] response;
  vocr_pkg::vocr_outcfg_s outCfg;
  vocr_pkg::vocr_gain_s rightGain;
  logic badGainWrite;
  logic reservedAccess;
  logic [31:0] q;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  vocr_regs dut_u (.sys_clk, .srst, .address, .read, .write, .byteenable, .writedata,
    .readdata, .waitrequest, .response, .outCfg, .rightGain, .badGainWrite, .reservedAccess);
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge sys_clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= d;
    // wait however long the answer takes; only the bench timeout ends a hang
    do
    begin
      @(posedge sys_clk);
    end
    while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    check({30'h0, response}, {30'h0, er});
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    bus(1'b0, vocr_pkg::RIGHT_GAIN_ADDR, 32'h0, 2'h0);
    check(q, 32'hCF);
    bus(1'b0, vocr_pkg::OUT_CFG_ADDR, 32'h0, 2'h0);
    check(q, 32'h51);
    check(32'(outCfg.switchMultiple), 32'h10);
    $display("reset test done");
  endtask
  task automatic t_gain;
    logic [7:0] c [4] = '{8'hFF, 8'h07, 8'h06, 8'hCE};
    foreach (c[i])
    begin
      bus(1'b1, vocr_pkg::RIGHT_GAIN_ADDR, {24'h0, c[i]}, 2'h0);
      bus(1'b0, vocr_pkg::RIGHT_GAIN_ADDR, 32'h0, 2'h0);
      check(q, {24'h0, c[i]});
      settle();
      check({31'h0, rightGain.muted}, {31'h0, c[i] < 8'h07});
      if (c[i] >= 8'h07)
        check(32'(rightGain.gainHalfDb), 32'({1'b0, c[i]}) - 32'd207);
    end
    byteenable <= 4'hE;
    bus(1'b1, vocr_pkg::RIGHT_GAIN_ADDR, 32'h0, 2'h0);
    byteenable <= 4'hF;
    bus(1'b0, vocr_pkg::RIGHT_GAIN_ADDR, 32'h0, 2'h0);
    check(q, 32'hCE);
    $display("gain test done");
  endtask
  task automatic t_cfg;
    logic [4:0] m [8] = '{5'h06, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18};
    logic [7:0] v;
    for (int r = 0; r < 8; r++)
    begin
      v = {r[0], r[2:0], 2'(r % 3), ~r[0], 1'b1};
      bus(1'b1, vocr_pkg::OUT_CFG_ADDR, {24'h0, v}, 2'h0);
      settle();
      check(32'(outCfg.switchMultiple), 32'(m[r]));
      check({28'h0, outCfg.parallelOutputSelect, outCfg.parallelSourceChannel,
        outCfg.analogGainCode}, {28'h0, v[7], v[1], v[3:2]});
    end
    check({31'h0, badGainWrite}, 32'h0);
    bus(1'b1, vocr_pkg::OUT_CFG_ADDR, 32'h5C, 2'h0);
    settle();
    check({31'h0, badGainWrite}, 32'h1);
    $display("config test done");
  endtask
  task automatic t_rate;
    for (int b = 1; b >= 0; b--)
    begin
      bus(1'b1, vocr_pkg::RATE_RANGE_ADDR, 32'(b), 2'h0);
      settle();
      check({30'h0, outCfg.halveSwitchRate, outCfg.sampleRateRangeSelect},
        32'(3 * b));
    end
    $display("rate test done");
  endtask
  task automatic t_rsvd;
    bus(1'b1, vocr_pkg::RSVD_ADDR, 32'hFF, 2'h2);
    bus(1'b0, vocr_pkg::RSVD_ADDR, 32'h0, 2'h2);
    check(q, 32'h0);
    check({31'h0, reservedAccess}, 32'h1);
    bus(1'b0, 8'h20, 32'h0, 2'h3);
    check(q, 32'h0);
    $display("reserved test done");
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_gain();
    t_cfg();
    t_rate();
    t_rsvd();
    end_of_test();
  end
endmodule
`default_nettype wire
